// >>> clk_gate_defines.svh
`ifndef CLK_GATE_DEFINES_SVH
`define CLK_GATE_DEFINES_SVH
// ****************************************
// register offsets
// ****************************************
`define OFS_SYS_EN 8'h00
`define OFS_SYS_DIS 8'h04
`define OFS_SYS_ST 8'h08
`define OFS_PER_EN 8'h10
`define OFS_PER_DIS 8'h14
`define OFS_PER_ST 8'h18
`define OFS_OSC 8'h20
`define OFS_FREQ 8'h24
`define OFS_PLL 8'h28
`define OFS_MCK 8'h30
`define OFS_PCK0 8'h40
`define OFS_PCK1 8'h44
`define OFS_IRQ_EN 8'h60
`define OFS_IRQ_DIS 8'h64
`define OFS_STATUS 8'h68
`define OFS_IRQ_MASK 8'h6C
`define OFS_FSTART 8'h70
`define OFS_IRQ_CLR 8'h78
// ****************************************
// fields and reset values
// ****************************************
`define PROC_BIT 0
`define PROG_LO 8
`define PROG_HI 10
`define PROG_MASK 32'h0000_0700
`define PROC_MASK 32'h0000_0001
`define OSC_KEY_LO 16
`define OSC_KEY_HI 23
`define OSC_KEY 8'h37
`define OSC_SEL_BIT 24
`define OSC_EN_BIT 0
`define MCK_FIELD_MASK 32'h0000_001F
`define MCK_RDY_BIT 3
`define PLL_RST 32'h0000_3F00
`define MCK_RST 32'h0000_0001
`define SYS_ST_RST 32'h0000_0001
`define STATUS_MASK 32'h0000_0708
`define RDY_CYCLES 4'h8
`endif

// >>> clk_gate_pkg.sv
package clk_gate_pkg;
  typedef enum logic [1:0] {
    MCK_READY = 2'b00,
    MCK_SWITCH = 2'b01
  } mck_state_t;
  typedef logic [31:0] word_t;
endpackage

// >>> clock_gating_register_interface.sv
`timescale 1ns/1ps
`include "clk_gate_defines.svh"
module clock_gating_register_interface import clk_gate_pkg::*; #(
  parameter logic [31:0] PERIPH_IMPL = 32'hFFFF_FFFC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic processor_clock_on,
  output logic [2:0] prog_clock_on,
  output logic [31:0] periph_clock_on,
  output logic fast_rc_enable,
  output logic main_source_select,
  output logic irq
);
  initial begin
    if (PERIPH_IMPL[1:0] != 2'b00)
      $error("peripheral ids 0 and 1 cannot be implemented");
  end
  // ****************************************
  // bus decode
  // ****************************************
  wire wr = psel && penable && pwrite;
  wire rd_setup = psel && !penable && !pwrite;
  wire w_sys_en = wr && paddr == `OFS_SYS_EN;
  wire w_sys_dis = wr && paddr == `OFS_SYS_DIS;
  wire w_per_en = wr && paddr == `OFS_PER_EN;
  wire w_per_dis = wr && paddr == `OFS_PER_DIS;
  wire w_osc = wr && paddr == `OFS_OSC &&
    pwdata[`OSC_KEY_HI:`OSC_KEY_LO] == `OSC_KEY;
  wire w_pll = wr && paddr == `OFS_PLL;
  wire w_mck = wr && paddr == `OFS_MCK;
  wire w_pck0 = wr && paddr == `OFS_PCK0;
  wire w_pck1 = wr && paddr == `OFS_PCK1;
  wire w_ien = wr && paddr == `OFS_IRQ_EN;
  wire w_idis = wr && paddr == `OFS_IRQ_DIS;
  wire w_iclr = wr && paddr == `OFS_IRQ_CLR;
  wire w_fst = wr && paddr == `OFS_FSTART;
  // ****************************************
  // state registers
  // ****************************************
  word_t sys_r, sys_nxt, per_r, per_nxt, osc_r, pll_r, mck_r, pck0_r, pck1_r;
  word_t imask_r, fst_r, sticky_r, sticky_nxt, status_w, rdata_nxt;
  mck_state_t mck_st_r, mck_st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [2:0] prog_rdy_r;
  function automatic word_t set_clr(word_t cur, word_t s, word_t c,
                                    word_t m);
    set_clr = (cur | (s & m)) & ~(c & m);
  endfunction
  assign sys_nxt = set_clr(sys_r, w_sys_en ? pwdata : '0,
    w_sys_dis ? pwdata : '0, `PROG_MASK) &
    ~((w_sys_dis ? pwdata : '0) & `PROC_MASK);
  assign per_nxt = set_clr(per_r, w_per_en ? pwdata : '0,
    w_per_dis ? pwdata : '0, PERIPH_IMPL);
  wire mck_change = w_mck && ((pwdata ^ mck_r) & `MCK_FIELD_MASK) != '0;
  always_comb begin
    mck_st_nxt = mck_st_r;
    cnt_nxt = cnt_r;
    case (mck_st_r)
      MCK_READY: begin
        if (mck_change) begin
          mck_st_nxt = MCK_SWITCH;
          cnt_nxt = `RDY_CYCLES;
        end
      end
      MCK_SWITCH: begin
        if (mck_change)
          cnt_nxt = `RDY_CYCLES;
        else if (cnt_r == 4'h1)
          mck_st_nxt = MCK_READY;
        else
          cnt_nxt = cnt_r - 4'h1;
      end
      default: mck_st_nxt = MCK_READY;
    endcase
  end
  wire mck_rdy = mck_st_r == MCK_READY;
  assign status_w = {21'h0, prog_rdy_r, 4'h0, mck_rdy, 3'h0};
  // set wins over clear
  assign sticky_nxt = (sticky_r & ~(w_iclr ? pwdata : '0)) |
    ({21'h0, sys_r[`PROG_HI:`PROG_LO] & ~prog_rdy_r, 8'h0}) |
    ({28'h0, mck_st_r == MCK_SWITCH && mck_st_nxt == MCK_READY, 3'h0});
  always_comb begin
    rdata_nxt = '0;
    if (paddr == `OFS_SYS_ST) rdata_nxt = sys_r;
    else if (paddr == `OFS_PER_ST) rdata_nxt = per_r;
    else if (paddr == `OFS_OSC) rdata_nxt = osc_r;
    else if (paddr == `OFS_PLL) rdata_nxt = pll_r;
    else if (paddr == `OFS_MCK) rdata_nxt = mck_r;
    else if (paddr == `OFS_PCK0) rdata_nxt = pck0_r;
    else if (paddr == `OFS_PCK1) rdata_nxt = pck1_r;
    else if (paddr == `OFS_STATUS) rdata_nxt = status_w;
    else if (paddr == `OFS_IRQ_MASK) rdata_nxt = imask_r;
    else if (paddr == `OFS_FSTART) rdata_nxt = fst_r;
    else if (paddr == `OFS_IRQ_CLR) rdata_nxt = sticky_r;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_r <= `SYS_ST_RST;
      per_r <= '0;
      osc_r <= 32'h0000_0001;
      pll_r <= `PLL_RST;
      mck_r <= `MCK_RST;
      pck0_r <= '0;
      pck1_r <= '0;
      imask_r <= '0;
      fst_r <= '0;
      sticky_r <= '0;
      mck_st_r <= MCK_READY;
      cnt_r <= 4'h0;
      prog_rdy_r <= 3'h0;
    end else begin
      sys_r <= sys_nxt;
      per_r <= per_nxt;
      if (w_osc)
        osc_r <= pwdata & 32'h0100_0001;
      if (w_pll) pll_r <= pwdata;
      if (w_mck) mck_r <= pwdata & `MCK_FIELD_MASK;
      if (w_pck0) pck0_r <= pwdata & `MCK_FIELD_MASK;
      if (w_pck1) pck1_r <= pwdata & `MCK_FIELD_MASK;
      if (w_fst) fst_r <= pwdata;
      imask_r <= (imask_r | (w_ien ? pwdata & `STATUS_MASK : '0)) &
        ~(w_idis ? pwdata : '0);
      sticky_r <= sticky_nxt & `STATUS_MASK;
      mck_st_r <= mck_st_nxt;
      cnt_r <= cnt_nxt;
      prog_rdy_r <= sys_r[`PROG_HI:`PROG_LO];
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      processor_clock_on <= 1'b1;
      prog_clock_on <= 3'h0;
      periph_clock_on <= '0;
      fast_rc_enable <= 1'b1;
      main_source_select <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (rd_setup) prdata <= rdata_nxt;
      pready <= psel && !penable;
      pslverr <= 1'b0;
      processor_clock_on <= sys_nxt[`PROC_BIT];
      prog_clock_on <= sys_nxt[`PROG_HI:`PROG_LO];
      periph_clock_on <= per_nxt;
      fast_rc_enable <= osc_r[`OSC_EN_BIT];
      main_source_select <= osc_r[`OSC_SEL_BIT];
      irq <= (sticky_nxt & imask_r & `STATUS_MASK) != '0;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  AST_PROG_ON: assert property (@(posedge pclk) disable iff (!presetn)
    w_sys_en && pwdata[8] |=> sys_r[8])
    else $error("prog clock enable lost");
  AST_PROG_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    w_sys_dis && pwdata[9] |=> !sys_r[9])
    else $error("prog clock disable lost");
  AST_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    w_sys_dis && pwdata[0] |=> !sys_r[0] ##1 !processor_clock_on)
    else $error("processor clock not stopped");
  AST_PROC_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(w_sys_dis && pwdata[0]) && !sys_r[0] |=> !sys_r[0])
    else $error("processor clock restarted");
  AST_PER_ON: assert property (@(posedge pclk) disable iff (!presetn)
    w_per_en && pwdata[5] && !w_per_dis |=> per_r[5] ##1 periph_clock_on[5])
    else $error("peripheral enable lost");
  AST_PER_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    w_per_dis && pwdata[7] |=> !per_r[7])
    else $error("peripheral disable lost");
  AST_PER_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    per_r[1:0] == 2'b00)
    else $error("unimplemented peripheral bit set");
  AST_KEY: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `OFS_OSC && pwdata[23:16] != 8'h37 |=> $stable(osc_r))
    else $error("bad key write accepted");
  AST_MCK: assert property (@(posedge pclk) disable iff (!presetn)
    mck_change |=> !mck_rdy [*8] ##1 mck_rdy)
    else $error("master ready timing wrong");
  COV_IDLE: cover property (@(posedge pclk) w_sys_dis && pwdata[0]);
  COV_KEY: cover property (@(posedge pclk) w_osc);
  COV_IRQ: cover property (@(posedge pclk) irq);
  COV_MCK: cover property (@(posedge pclk) mck_change);
  COV_PER: cover property (@(posedge pclk) w_per_dis);
endmodule

// >>> clock_gating_register_interface_bench.sv
`timescale 1ns/1ps
`include "clk_gate_defines.svh"
module clock_gating_register_interface_bench;
  import clk_gate_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, periph_clock_on;
  logic pready, pslverr, processor_clock_on, fast_rc_enable;
  logic main_source_select, irq;
  logic [2:0] prog_clock_on;
  word_t rd;
  int errors = 0, compares = 0, cyc = 0;
  clock_gating_register_interface dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .processor_clock_on(processor_clock_on), .prog_clock_on(prog_clock_on),
    .periph_clock_on(periph_clock_on), .fast_rc_enable(fast_rc_enable),
    .main_source_select(main_source_select), .irq(irq));
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      finish_test();
    end
  end
  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input word_t d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      finish_test();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input word_t got, input word_t exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input word_t m, input word_t e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & m, e);
  endtask
  task automatic finish_test();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`OFS_SYS_ST, 32'hFFFF_FFFF, 32'h0000_0001);
    rchk(`OFS_PER_ST, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk(`OFS_OSC, 32'h0100_0001, 32'h0000_0001);
    rchk(`OFS_SYS_EN, 32'hFFFF_FFFF, 32'h0000_0000);
    chk({fast_rc_enable, main_source_select, irq}, 32'h4);
    $display("test reset done");
    apb(1'b1, `OFS_SYS_EN, 32'h0000_0500);
    rchk(`OFS_SYS_ST, 32'hFFFF_FFFF, 32'h0000_0501);
    apb(1'b1, `OFS_SYS_EN, 32'h0000_0000);
    apb(1'b1, `OFS_SYS_DIS, 32'h0000_0100);
    rchk(`OFS_SYS_ST, 32'hFFFF_FFFF, 32'h0000_0401);
    chk(prog_clock_on, 32'h4);
    apb(1'b1, `OFS_SYS_DIS, 32'h0000_0001);
    rchk(`OFS_SYS_ST, 32'hFFFF_FFFF, 32'h0000_0400);
    chk(processor_clock_on, 32'h0);
    $display("test system clocks done");
    apb(1'b1, `OFS_PER_EN, 32'hFFFF_FFFF);
    rchk(`OFS_PER_ST, 32'hFFFF_FFFF, 32'hFFFF_FFFC);
    apb(1'b1, `OFS_PER_DIS, 32'h0000_0110);
    apb(1'b1, `OFS_PER_DIS, 32'h0000_0000);
    rchk(`OFS_PER_ST, 32'hFFFF_FFFF, 32'hFFFF_FEEC);
    chk(periph_clock_on, 32'hFFFF_FEEC);
    $display("test peripheral clocks done");
    apb(1'b1, `OFS_OSC, 32'h0136_0000);
    rchk(`OFS_OSC, 32'h0100_0001, 32'h0000_0001);
    apb(1'b1, `OFS_OSC, 32'h0137_0000);
    rchk(`OFS_OSC, 32'h0100_0001, 32'h0100_0000);
    chk({fast_rc_enable, main_source_select}, 32'h1);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    rchk(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk(`OFS_SYS_ST, 32'hFFFF_FFFF, 32'h0000_0400);
    $display("test oscillator and reserved done");
    apb(1'b1, `OFS_IRQ_EN, 32'h0000_0100);
    apb(1'b1, `OFS_IRQ_CLR, 32'hFFFF_FFFF);
    rchk(`OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0100);
    chk(irq, 32'h0);
    apb(1'b1, `OFS_SYS_EN, 32'h0000_0100);
    rchk(`OFS_STATUS, 32'h0000_0700, 32'h0000_0500);
    chk(irq, 32'h1);
    rchk(`OFS_IRQ_CLR, 32'h0000_0100, 32'h0000_0100);
    apb(1'b1, `OFS_IRQ_DIS, 32'h0000_0100);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    apb(1'b1, `OFS_IRQ_EN, 32'h0000_0100);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h1);
    apb(1'b1, `OFS_IRQ_CLR, 32'h0000_0100);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    $display("test interrupt done");
    apb(1'b1, `OFS_MCK, 32'h0000_0011);
    rchk(`OFS_STATUS, 32'h0000_0008, 32'h0000_0000);
    repeat (16) @(posedge pclk);
    rchk(`OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
    $display("test master ready done");
    finish_test();
  end
endmodule
